/* File: hdl/flash_host.v */
// Host controller driving a parallel flash over its bus pins
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host #(
  parameter WAKE_WRITE_NS = 1000,
  parameter WAKE_READ_NS = 1000,
  parameter READ_ACCESS_NS = 100,
  parameter WE_PULSE_NS = 50
) (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire [4:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [4:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  output reg [18:0] o_addr,
  output reg o_byte_sel,
  output reg [15:0] o_dq,
  output reg o_dq_oe_lo,
  output reg o_dq_oe_hi,
  input wire [15:0] i_dq,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n,
  output reg o_reset_powerdown_n,
  output wire o_rp_override,
  output wire o_boot_unlock,
  output wire o_word_mode,
  input wire i_ready_busy_n
);
  // Cycle counts, least times round up
  localparam [15:0] WAKE_WR_CYC =
    (WAKE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [15:0] WAKE_RD_CYC =
    (WAKE_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [15:0] RD_CYC =
    (READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
  localparam [15:0] WE_CYC =
    (WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [15:0] PD_CYC = `PD_LOW_MIN_CYC;
  localparam [15:0] ONE = 16'h0001;
  // One-hot bus states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SETUP = 5'h02;
  localparam [4:0] S_STROBE = 5'h04;
  localparam [4:0] S_HOLD = 5'h08;
  localparam [4:0] S_READ = 5'h10;

  // Codes the device defines; anything else is reserved
  function is_known_cmd;
    input [7:0] code;
    begin
      case (code)
        `CMD_READ_ARRAY, `CMD_READ_ID, `CMD_READ_STATUS,
        `CMD_CLEAR_STATUS, `CMD_ERASE_SETUP, `CMD_CONFIRM,
        `CMD_PROG_SETUP, `CMD_PROG_ALT, `CMD_SUSPEND: is_known_cmd = 1'b1;
        default: is_known_cmd = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] ctrl;
  reg [19:0] addr;
  reg [15:0] wdata;
  reg [15:0] rdata;
  reg refused, narrow, erase_pend, prog_pend;
  reg [4:0] state, next_state;
  reg [15:0] cnt, pd_cnt, wake_cnt;
  reg aw_got, w_got;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [1:0] cur_op;
  wire idle = state[0];
  wire rd_ok, wr_ok, do_write, go_req, next_byte;
  wire [1:0] req_op;
  wire [7:0] req_code;
  reg go_bad;

  // Pin levels set straight from control
  assign o_rp_override = ctrl[`CTRL_OVR]; // [RL18]
  assign o_boot_unlock = ctrl[`CTRL_UNLOCK]; // [RL18]
  assign o_word_mode = ~ctrl[`CTRL_BYTE]; // [RL21]

  // Reads wait wake-to-read, writes wait both that and the wake-to-write interval
  assign rd_ok = o_reset_powerdown_n && (wake_cnt >= WAKE_RD_CYC); // [RL10]
  assign wr_ok = o_reset_powerdown_n && (wake_cnt >= WAKE_WR_CYC); // [RL8]

  // Write channels: each held until both have arrived
  assign o_awready = !aw_got && !o_bvalid;
  assign o_wready = !w_got && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign do_write = aw_got && w_got && !o_bvalid;
  assign go_req = do_write && (aw_addr == {1'b0, `REG_CTRL}) &&
    w_strb[0] && w_data[`CTRL_GO];
  assign req_op = w_data[`CTRL_OP_HI:`CTRL_OP_LO];
  assign req_code = wdata[7:0];
  // Width of a cycle started by this very write, not the stale setting
  assign next_byte = (do_write && aw_addr == {1'b0, `REG_CTRL} &&
    w_strb[0]) ? w_data[`CTRL_BYTE] : ctrl[`CTRL_BYTE];

  // Decide whether a start is legal before it reaches the pins
  always @* begin
    go_bad = 1'b0;
    if (!idle || !rd_ok || req_op == 2'h3) begin
      go_bad = 1'b1;
    end else if (req_op != `OP_READ) begin
      if (!wr_ok) begin
        go_bad = 1'b1; // [RL25]
      end else if (req_op == `OP_CMD && !is_known_cmd(req_code)) begin
        go_bad = 1'b1; // [RL11]
      end else if (erase_pend &&
                   (req_op != `OP_CMD || req_code != `CMD_CONFIRM)) begin
        go_bad = 1'b1; // [RL15]
      end else if (prog_pend && req_op != `OP_DATA) begin
        go_bad = 1'b1; // [RL16]
      end else if (req_op == `OP_DATA && !prog_pend) begin
        go_bad = 1'b1; // [RL16]
      end
    end
  end

  // AXI4-Lite register slave
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp <= `RESP_OKAY;
      o_rdata <= 32'h00000000;
      ctrl <= 8'h00;
      addr <= 20'h00000;
      wdata <= 16'h0000;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_got <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= `RESP_OKAY;
        case (aw_addr)
          {1'b0, `REG_CTRL}: begin
            // Go is a strobe and never stays stored
            if (w_strb[0]) begin
              ctrl <= {w_data[7:1], 1'b0};
            end
          end
          {1'b0, `REG_ADDR}: begin
            if (w_strb[0]) addr[7:0] <= w_data[7:0];
            if (w_strb[1]) addr[15:8] <= w_data[15:8];
            if (w_strb[2]) addr[19:16] <= w_data[19:16];
          end
          {1'b0, `REG_WDATA}: begin
            if (w_strb[0]) wdata[7:0] <= w_data[7:0];
            if (w_strb[1]) wdata[15:8] <= w_data[15:8];
          end
          `REG_STATUS, {1'b0, `REG_RDATA}: begin
          end
          default: o_bresp <= `RESP_SLVERR;
        endcase
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= `RESP_OKAY;
        case (i_araddr)
          {1'b0, `REG_CTRL}: o_rdata <= {24'h000000, ctrl};
          {1'b0, `REG_ADDR}: o_rdata <= {12'h000, addr};
          {1'b0, `REG_WDATA}: o_rdata <= {16'h0000, wdata};
          {1'b0, `REG_RDATA}: o_rdata <= {16'h0000, rdata};
          `REG_STATUS: o_rdata <= {27'h0000000, narrow, refused,
            !wr_ok, i_ready_busy_n, !idle}; // [RL19]
          default: begin
            o_rdata <= 32'h00000000;
            o_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Bus cycle sequencing
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (go_req && !go_bad) begin
          next_state = (req_op == `OP_READ) ? S_READ : S_SETUP; // [RL2]
        end
      end
      S_SETUP: next_state = S_STROBE;
      S_STROBE: if (cnt >= WE_CYC) next_state = S_HOLD;
      S_HOLD: next_state = S_IDLE;
      S_READ: if (cnt >= RD_CYC) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // Strobes are registered so they never glitch on the pins
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= S_IDLE;
      cnt <= 16'h0000;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_dq_oe_lo <= 1'b0;
      o_dq_oe_hi <= 1'b0;
      o_dq <= 16'h0000;
      o_addr <= 19'h00000;
      o_byte_sel <= 1'b0;
      cur_op <= `OP_READ;
      rdata <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= (next_state == state) ? cnt + ONE : ONE;
      // Select low through the whole cycle; high between cycles
      o_ce_n <= next_state[0]; // [RL4]
      // Gate and strobe come from disjoint states
      o_oe_n <= ~next_state[4]; // [RL20]
      // Device latches when the strobe rises, select stays low one more
      o_we_n <= ~next_state[2]; // [RL9]
      o_dq_oe_lo <= next_state[1] | next_state[2] | next_state[3]; // [RL3]
      o_dq_oe_hi <= (next_state[1] | next_state[2] | next_state[3]) &&
        !next_byte; // [RL21]
      if (idle && next_state != S_IDLE) begin
        o_addr <= addr[18:0];
        o_byte_sel <= addr[19]; // [RL21]
        o_dq <= wdata;
        cur_op <= req_op;
      end
      // Sample at the last cycle of the access window
      if (state[4] && next_state[0]) begin
        if (ctrl[`CTRL_BYTE] || narrow) begin
          rdata <= {8'h00, i_dq[7:0]}; // [RL24]
        end else begin
          rdata <= i_dq;
        end
      end
    end
  end

  // Track the device's read mode and the two-write sequences
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      narrow <= 1'b0;
      erase_pend <= 1'b0;
      prog_pend <= 1'b0;
      refused <= 1'b0;
    end else begin
      // A fresh refusal outranks a clear in the same cycle
      if (go_req && go_bad) begin
        refused <= 1'b1;
      end else if (do_write && aw_addr == `REG_STATUS && w_strb[0] &&
                   w_data[`ST_REFUSED]) begin
        refused <= 1'b0;
      end
      if (!o_reset_powerdown_n) begin
        // Wake puts the device back in array mode
        narrow <= 1'b0; // [RL6]
        erase_pend <= 1'b0; // [RL7]
        prog_pend <= 1'b0;
      end else if (state[3]) begin
        erase_pend <= 1'b0;
        prog_pend <= 1'b0;
        if (cur_op == `OP_DATA) begin
          narrow <= 1'b1; // [RL22]
        end else begin
          case (o_dq[7:0])
            `CMD_READ_ARRAY: narrow <= 1'b0; // [RL11]
            `CMD_READ_ID: narrow <= 1'b1; // [RL13] [RL23]
            `CMD_READ_STATUS: narrow <= 1'b1; // [RL14]
            `CMD_CONFIRM: narrow <= 1'b1; // [RL17]
            `CMD_SUSPEND: narrow <= 1'b1; // [RL17]
            `CMD_ERASE_SETUP: erase_pend <= 1'b1; // [RL15]
            `CMD_PROG_SETUP, `CMD_PROG_ALT: prog_pend <= 1'b1; // [RL16]
            default: narrow <= narrow; // Clear status keeps the mode [RL12]
          endcase
        end
      end
    end
  end

  // Reset line: held low from reset, at least the minimum once lowered
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reset_powerdown_n <= 1'b0; // [RL1]
      pd_cnt <= 16'h0000;
      wake_cnt <= 16'h0000;
    end else begin
      if (!o_reset_powerdown_n) begin
        wake_cnt <= 16'h0000;
        if (pd_cnt < PD_CYC) pd_cnt <= pd_cnt + ONE;
        // Release only between bus cycles and after the least low time
        if (idle && !ctrl[`CTRL_PD] && pd_cnt >= PD_CYC) begin
          o_reset_powerdown_n <= 1'b1; // [RL5]
        end
      end else begin
        pd_cnt <= 16'h0000;
        if (wake_cnt < WAKE_WR_CYC || wake_cnt < WAKE_RD_CYC) begin
          wake_cnt <= wake_cnt + ONE; // [RL8]
        end
        if (idle && ctrl[`CTRL_PD]) begin
          o_reset_powerdown_n <= 1'b0; // [RL5]
        end
      end
    end
  end
endmodule // flash_host

/* File: hdl/flash_host_regs.vh */
// Constants of the parallel flash bus host controller
// Functional notes
// [RL1] Device wakes in read array mode
// [RL2] Read: select and gate low, strobe high
// [RL3] Gate high floats all sixteen data pins
// [RL4] Select high means standby, outputs float
// [RL5] Reset line held low at least 100ns
// [RL6] Wake returns read array, status 80H
// [RL7] Reset low aborts erase or program
// [RL8] Wait wake-to-write time before command writes
// [RL9] Write latched on first rising select/strobe
// [RL10] Low program supply blocks memory changes
// [RL11] FFH reads array; reserved codes never issued
// [RL12] 50H clears the status register
// [RL13] 90H selects identifier reads
// [RL14] 70H selects status reads
// [RL15] Erase: 20H then D0H in block
// [RL16] Program: 40H or 10H, then data
// [RL17] D0H resumes, B0H suspends
// [RL18] Boot blocks need unlock pin or override
// [RL19] Ready/busy low while algorithm runs
// [RL20] Never gate and strobe low together
// [RL21] Byte mode uses low data byte only
// [RL22] After erase or program reads return status
// [RL23] Identifier codes at addresses 0 and 1
// [RL24] Status and identifier use low byte only
// [RL25] Writes ignored while reset or waking
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH
// Register byte offsets
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_RDATA 4'hC
// Status sits above the nibble of the others
`define REG_STATUS 5'h10
// Control fields
`define CTRL_GO 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 2
`define CTRL_BYTE 4
`define CTRL_UNLOCK 5
`define CTRL_PD 6
`define CTRL_OVR 7
// Operations
`define OP_READ 2'h0
`define OP_CMD 2'h1
`define OP_DATA 2'h2
// Status fields
`define ST_BUSY 0
`define ST_RB 1
`define ST_WAKE 2
`define ST_REFUSED 3
`define ST_NARROW 4
// Command codes
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_ID 8'h90
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_PROG_SETUP 8'h40
`define CMD_PROG_ALT 8'h10
`define CMD_SUSPEND 8'hB0
// Timing
`define CLK_PERIOD_NS 25
`define PD_LOW_MIN_NS 100
`define PD_LOW_MIN_CYC ((`PD_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: verif/flash_dev.sv */
// Behavioural parallel flash standing at the host's far side
`timescale 1ns/1ps
module flash_dev #(
  parameter MAKER = 8'h5C, // Arbitrary identity value
  parameter PART = 8'h3E, // Arbitrary identity value
  parameter BUSY_NS = 3000
) (
  input wire [18:0] i_addr,
  input wire i_byte_sel,
  input wire [15:0] i_dq,
  input wire i_ce_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire i_rp_n,
  input wire i_rp_hi,
  input wire i_unlock,
  input wire i_word,
  output wire [15:0] o_dq,
  output wire o_rb_low
);
  reg [15:0] mem [0:15];
  reg [15:0] rd;
  reg [7:0] last = 8'h00;
  reg [6:0] err = 7'h00;
  reg [1:0] mode = 2'h0; // Array reads after power-up
  reg sp = 1'h0, se = 1'h0, susp = 1'h0;
  integer left = 0, k;
  wire [15:0] arr = mem[i_addr[3:0]];
  // Busy while running; held low through reset
  wire run = left > 0 && !susp;
  // Top boot blocks need unlock pin or override level
  wire lock = i_addr[18:13] == 6'h3F && !i_unlock && !i_rp_hi;
  // Drives only when selected, gated and awake
  wire drv = !i_ce_n && !i_oe_n && i_we_n && i_rp_n;
  // Floating lanes show a changing pattern, never the last value
  assign o_dq = drv ? rd : {~last, ~last};
  assign o_rb_low = run;
  initial begin
    for (k = 0; k < 16; k = k + 1)
      mem[k] = 16'hFFFF;
  end
  // Read data by mode; narrow modes float the upper lanes
  always @* begin
    if (mode == 2'h2)
      rd = {~last, !run, err};
    else if (mode == 2'h1)
      rd = {~last, i_addr[0] ? PART : MAKER};
    else if (!i_word)
      rd = {~last, i_byte_sel ? arr[15:8] : arr[7:0]};
    else
      rd = arr;
  end
  // Algorithm time passes only while awake and not suspended
  always begin
    #25;
    if (run && i_rp_n)
      left = left - 1;
  end
  // Wake aborts and restarts in array mode, status 80H
  always @(posedge i_rp_n) begin
    left = 0;
    susp = 1'h0;
    sp = 1'h0;
    se = 1'h0;
    mode = 2'h0;
    err = 7'h00;
  end
  // Capture on the strobe rise while selected and awake
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_rp_n) begin
      last = i_dq[7:0];
      if (sp || se) begin
        mode = 2'h2;
        if (lock)
          err = err | (sp ? 7'h12 : 7'h22);
        else if (sp) begin
          mem[i_addr[3:0]] = arr & i_dq;
          left = BUSY_NS / 25;
        end else if (last == 8'hD0) begin
          for (k = 0; k < 16; k = k + 1)
            mem[k] = 16'hFFFF;
          left = BUSY_NS / 25;
        end
        sp = 1'h0;
        se = 1'h0;
      end else begin
        case (last)
          8'hFF: mode = 2'h0;
          8'h90: mode = 2'h1;
          8'h70: mode = 2'h2;
          8'h50: err = 7'h00;
          8'h40, 8'h10: sp = 1'h1;
          8'h20: se = 1'h1;
          8'hB0: susp = left > 0;
          8'hD0: susp = 1'h0;
          default: ;
        endcase
      end
    end
  end
endmodule // flash_dev

/* File: verif/flash_host_monitor.sv */
// Checker on the flash host controller ports
`timescale 1ns/1ps
module flash_host_monitor #(
  parameter WAKE_WRITE_NS = 1000
) (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire i_bready,
  input wire o_bvalid,
  input wire [1:0] o_bresp,
  input wire [18:0] o_addr,
  input wire [15:0] o_dq,
  input wire o_dq_oe_lo,
  input wire o_dq_oe_hi,
  input wire o_ce_n,
  input wire o_oe_n,
  input wire o_we_n,
  input wire o_reset_powerdown_n,
  input wire o_word_mode
);
  // One cycle of slack for where the host starts its wake count
  localparam int WCYC = WAKE_WRITE_NS / 25 - 1;
  int wake;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Cycles since the reset line rose, saturating
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst || !o_reset_powerdown_n)
      wake <= 0;
    else if (wake < 1000)
      wake <= wake + 1;
  end
  a_gate_strobe_apart: assert property (o_oe_n || o_we_n)
    else $error("gate and strobe low together");
  a_read_levels: assert property (!o_oe_n |-> !o_ce_n && o_we_n
    && o_reset_powerdown_n && !o_dq_oe_lo && !o_dq_oe_hi)
    else $error("bad levels in read");
  a_drive_in_cycle: assert property (o_dq_oe_lo |-> !o_ce_n && o_oe_n)
    else $error("data driven outside write");
  a_byte_upper_idle: assert property (!o_word_mode |-> !o_dq_oe_hi)
    else $error("upper lanes driven in byte mode");
  a_write_framed: assert property (!o_we_n |-> !o_ce_n &&
    o_dq_oe_lo && $stable(o_addr) && $stable(o_dq))
    else $error("write strobe without stable cycle");
  a_strobe_first: assert property ($rose(o_we_n) |-> !o_ce_n ##1 o_ce_n)
    else $error("select did not end after strobe");
  a_pd_width: assert property ($fell(o_reset_powerdown_n) |->
    !o_reset_powerdown_n [*4])
    else $error("reset line pulse too short");
  a_pd_idle: assert property (!o_reset_powerdown_n |-> o_ce_n && o_we_n)
    else $error("access while reset line low");
  a_wake_write: assert property (!o_we_n |-> wake >= WCYC)
    else $error("write before wake time");
  a_b_stands: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  c_write: cover property (!o_we_n);
  c_byte_read: cover property (!o_oe_n && !o_word_mode);
  c_pd: cover property ($fell(o_reset_powerdown_n));
endmodule // flash_host_monitor
bind flash_host flash_host_monitor #(.WAKE_WRITE_NS(WAKE_WRITE_NS))
  flash_host_monitor_i (.*);

/* File: verif/flash_host_tb_top.sv */
// Bench driving the flash host over AXI4-Lite against the flash model
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host_tb_top;
  reg i_mclk = 1'h0;
  reg i_sys_rst = 1'h1;
  reg [4:0] i_awaddr = 5'h00, i_araddr = 5'h00;
  reg [31:0] i_wdata = 32'h0;
  reg [3:0] i_wstrb = 4'hF;
  reg i_awvalid = 1'h0, i_wvalid = 1'h0, i_arvalid = 1'h0;
  reg i_bready = 1'h0, i_rready = 1'h0;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire [18:0] o_addr;
  wire [15:0] o_dq, i_dq, fdq;
  wire o_byte_sel, o_dq_oe_lo, o_dq_oe_hi, o_ce_n, o_oe_n, o_we_n;
  wire o_reset_powerdown_n, o_rp_override, o_boot_unlock, o_word_mode;
  wire i_ready_busy_n, rbl;
  integer mismatches = 0, checked = 0;
  reg [31:0] ctl = 32'h0, v;
  reg [1:0] rsp;
  always #12.5 i_mclk = ~i_mclk;
  // Resolved data wire: host lanes win while enabled
  assign i_dq[15:8] = o_dq_oe_hi ? o_dq[15:8] : fdq[15:8];
  assign i_dq[7:0] = o_dq_oe_lo ? o_dq[7:0] : fdq[7:0];
  assign i_ready_busy_n = ~rbl; // Pull-up on the open drain
  flash_host #(.WAKE_WRITE_NS(500), .WAKE_READ_NS(500)) flash_host_i (.*);
  flash_dev flash_dev_i (.i_addr(o_addr), .i_byte_sel(o_byte_sel),
    .i_dq(i_dq), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_rp_n(o_reset_powerdown_n), .i_rp_hi(o_rp_override),
    .i_unlock(o_boot_unlock), .i_word(o_word_mode), .o_dq(fdq),
    .o_rb_low(rbl));
  task stop_test;
    begin
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [31:0] s, input [31:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // Sampling 1 ns after the edge sees what the next edge will take;
  // bready trails bvalid by a cycle so the response must stand meanwhile
  task wr(input [4:0] a, input [31:0] d, input [1:0] e);
    reg ta, tw, tb, sb;
    begin
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      tb = 1'h0;
      while (!tb) begin
        #1;
        ta = i_awvalid && o_awready;
        tw = i_wvalid && o_wready;
        sb = o_bvalid;
        tb = o_bvalid && i_bready;
        if (tb)
          check(o_bresp, e);
        @(posedge i_mclk);
        if (ta)
          i_awvalid <= 1'h0;
        if (tw)
          i_wvalid <= 1'h0;
        if (sb && !tb)
          i_bready <= 1'h1;
      end
      i_bready <= 1'h0;
      @(posedge i_mclk);
    end
  endtask
  task rd(input [4:0] a, output [31:0] d);
    reg ta, tr;
    begin
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      tr = 1'h0;
      while (!tr) begin
        #1;
        ta = i_arvalid && o_arready;
        tr = o_rvalid;
        d = o_rdata;
        rsp = o_rresp;
        @(posedge i_mclk);
        if (ta)
          i_arvalid <= 1'h0;
      end
      i_rready <= 1'h0;
      @(posedge i_mclk);
    end
  endtask
  task poll(input integer b, input x);
    integer n;
    begin
      n = 0;
      rd(`REG_STATUS, v);
      while (v[b] !== x && n < 300) begin
        rd(`REG_STATUS, v);
        n = n + 1;
      end
      if (n == 300)
        check(v, ~v);
    end
  endtask
  task go(input [1:0] op, input [19:0] a, input [15:0] d);
    begin
      wr(`REG_ADDR, a, `RESP_OKAY);
      wr(`REG_WDATA, d, `RESP_OKAY);
      wr(`REG_CTRL, ctl | {op, 1'h1}, `RESP_OKAY);
      poll(`ST_BUSY, 1'h0);
    end
  endtask
  task cmd(input [7:0] c, input [19:0] a);
    go(`OP_CMD, a, c);
  endtask
  task rdf(input [19:0] a, input [15:0] e);
    begin
      go(`OP_READ, a, 16'h0);
      rd(`REG_RDATA, v);
      check(v, e);
    end
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'h0;
    poll(`ST_WAKE, 1'h0);
    rdf(20'h3, 16'hFFFF);
    cmd(8'h90, 20'h0);
    rdf(20'h0, 16'h5C);
    rdf(20'h1, 16'h3E);
    cmd(8'h70, 20'h0);
    rdf(20'h0, 16'h80);
    $display("test read modes done");
    cmd(8'h40, 20'h2);
    go(`OP_DATA, 20'h2, 16'h1234);
    rd(`REG_STATUS, v);
    check(v[`ST_RB], 1'h0);
    rdf(20'h2, 16'h00);
    poll(`ST_RB, 1'h1);
    rdf(20'h2, 16'h80);
    cmd(8'h10, 20'h3);
    go(`OP_DATA, 20'h3, 16'h00F0);
    poll(`ST_RB, 1'h1);
    cmd(8'hFF, 20'h0);
    rdf(20'h2, 16'h1234);
    rdf(20'h3, 16'h00F0);
    $display("test program done");
    cmd(8'h20, 20'h5);
    cmd(8'hD0, 20'h5);
    cmd(8'hB0, 20'h0);
    rd(`REG_STATUS, v);
    check(v[`ST_RB], 1'h1);
    cmd(8'hD0, 20'h0);
    rd(`REG_STATUS, v);
    check(v[`ST_RB], 1'h0);
    poll(`ST_RB, 1'h1);
    cmd(8'hFF, 20'h0);
    rdf(20'h2, 16'hFFFF);
    $display("test erase done");
    cmd(8'h40, 20'h7F000);
    go(`OP_DATA, 20'h7F000, 16'h0);
    rdf(20'h0, 16'h92);
    cmd(8'h50, 20'h0);
    rdf(20'h0, 16'h80);
    ctl = 32'h20;
    cmd(8'h40, 20'h7F000);
    go(`OP_DATA, 20'h7F000, 16'hAB12);
    poll(`ST_RB, 1'h1);
    ctl = 32'h80;
    cmd(8'h40, 20'h7E001);
    go(`OP_DATA, 20'h7E001, 16'h00CD);
    poll(`ST_RB, 1'h1);
    ctl = 32'h0;
    cmd(8'hFF, 20'h0);
    rdf(20'h7F000, 16'hAB12);
    rdf(20'h7E001, 16'h00CD);
    cmd(8'h33, 20'h0);
    rd(`REG_STATUS, v);
    check(v[`ST_REFUSED], 1'h1);
    wr(`REG_STATUS, 32'h8, `RESP_OKAY);
    rd(`REG_STATUS, v);
    check(v[`ST_REFUSED], 1'h0);
    wr(5'h14, 32'h0, `RESP_SLVERR);
    rd(5'h14, v);
    check(rsp, `RESP_SLVERR);
    ctl = 32'h10;
    cmd(8'hFF, 20'h0);
    rdf(20'h80000, 16'hAB);
    rdf(20'h00000, 16'h12);
    $display("test protect and byte done");
    ctl = 32'h0;
    cmd(8'h40, 20'h6);
    go(`OP_DATA, 20'h6, 16'h5555);
    wr(`REG_WDATA, 32'h70, `RESP_OKAY);
    wr(`REG_CTRL, 32'h40, `RESP_OKAY);
    repeat (8) @(posedge i_mclk);
    rd(`REG_STATUS, v);
    check(v[`ST_RB], 1'h0);
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    wr(`REG_CTRL, 32'h3, `RESP_OKAY);
    rd(`REG_STATUS, v);
    check(v[`ST_REFUSED], 1'h1);
    poll(`ST_WAKE, 1'h0);
    rd(`REG_STATUS, v);
    check(v[`ST_RB], 1'h1);
    rdf(20'h4, 16'hFFFF);
    cmd(8'h70, 20'h0);
    rdf(20'h0, 16'h80);
    $display("test power-down done");
    stop_test;
  end
endmodule // flash_host_tb_top
